// ### verilog/lin_cfg_host.sv
/*
  host end: an AXI4-Lite slave whose command register sends one 16-bit
  frame over the link and whose response register holds the answer.
  assumes the device answers on miso; link clock is made here by a divider.
*/
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module lin_cfg_host (
  input  wire logic        clk,
  input  wire logic        reset,
  lin_cfg_if.host          link,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10,
    ST_TAIL = 2'b11
  } link_e;

  link_e       st_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [15:0] tx_r;
  logic [15:0] resp_r;
  logic [4:0]  bits_r;
  logic [3:0]  tick_r;
  logic        done_r;
  logic        miso_s1_r;
  logic        miso_s2_r;

  wire busy      = (st_r != ST_IDLE);
  wire do_write  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire hit_cmd   = do_write & (awaddr_r == lin_cfg_pkg::REG_CMD);
  wire hit_stat  = do_write & (awaddr_r == lin_cfg_pkg::REG_STATUS);
  wire wr_ok     = (awaddr_r == lin_cfg_pkg::REG_CMD) |
                   (awaddr_r == lin_cfg_pkg::REG_STATUS);
  wire start     = hit_cmd & ~busy & (&wstrb_r[1:0]);
  // reserved frame positions go out as zero for the PHY and SM addresses; other addresses go out unmasked
  wire [1:0]  cmd_addr =
    wdata_r[lin_cfg_pkg::ADDR_HI:lin_cfg_pkg::ADDR_LO];
  wire [15:0] cmd_mask =
    (cmd_addr == lin_cfg_pkg::ADDR_PHY) ? 16'hf01d :
    (cmd_addr == lin_cfg_pkg::ADDR_SM)  ? 16'hf278 :
    16'hffff;
  wire tick_end  = (tick_r == 4'(lin_cfg_pkg::SCLK_HALF - 1));
  wire last_bit  = (bits_r == 5'(lin_cfg_pkg::FRAME_BITS - 1));
  wire frame_end = (st_r == ST_TAIL) & tick_end;
  wire done_clr  = hit_stat & wstrb_r[0] & wdata_r[lin_cfg_pkg::ST_DONE];
  wire rd_cmd    = (s_axi_araddr == lin_cfg_pkg::REG_CMD);
  wire rd_stat   = (s_axi_araddr == lin_cfg_pkg::REG_STATUS);
  wire rd_resp   = (s_axi_araddr == lin_cfg_pkg::REG_RESP);
  wire [31:0] rd_data =
    rd_cmd  ? {16'h0000, tx_r} :
    rd_stat ? {30'h0, done_r, busy} :
    rd_resp ? {16'h0000, resp_r} : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= lin_cfg_pkg::RESP_OKAY;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? lin_cfg_pkg::RESP_OKAY
                              : lin_cfg_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lin_cfg_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= (rd_cmd | rd_stat | rd_resp) ?
                       lin_cfg_pkg::RESP_OKAY : lin_cfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // done flag: frame end wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      done_r <= 1'b0;
    else if (frame_end)
      done_r <= 1'b1;
    else if (done_clr)
      done_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end
    else
    begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // link sequencer: msb first, data changes on low phase, sampled on rise
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r       <= ST_IDLE;
      tx_r       <= 16'h0000;
      resp_r     <= 16'h0000;
      bits_r     <= 5'h00;
      tick_r     <= 4'h0;
      link.sclk  <= 1'b0;
      link.csn_n <= 1'b1;
      link.mosi  <= 1'b0;
    end
    else
    begin
      tick_r <= (busy && !tick_end) ? tick_r + 4'h1 : 4'h0;
      case (st_r)
        ST_IDLE:
          if (start)
          begin
            tx_r       <= wdata_r[15:0] & cmd_mask;
            link.csn_n <= 1'b0;
            link.mosi  <= wdata_r[15];
            bits_r     <= 5'h00;
            st_r       <= ST_LOW;
          end
        ST_LOW:
          if (tick_end)
          begin
            link.sclk <= 1'b1;
            resp_r    <= {resp_r[14:0], miso_s2_r};
            st_r      <= ST_HIGH;
          end
        ST_HIGH:
          if (tick_end)
          begin
            link.sclk <= 1'b0;
            bits_r    <= bits_r + 5'h01;
            if (last_bit)
              st_r <= ST_TAIL;
            else
            begin
              link.mosi <= tx_r[4'(14 - bits_r)];
              st_r      <= ST_LOW;
            end
          end
        ST_TAIL:
          if (tick_end)
          begin
            link.csn_n <= 1'b1;
            st_r       <= ST_IDLE;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // lin_cfg_host

// ### verilog/lin_cfg_pkg.sv
/*
  constants shared by both ends of the register frame link: frame layout,
  register addresses, field positions, prescale and threshold lookups, host map, timing.
  assumes a 100 MHz system clock on both ends.
*/
package lin_cfg_pkg;
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned ADDR_HI      = 15;
  localparam int unsigned ADDR_LO      = 14;
  localparam int unsigned SEL_BIT      = 13;
  localparam int unsigned INHIBIT_BIT  = 12;
  localparam logic [1:0]  ADDR_PHY     = 2'h3;
  localparam logic [1:0]  ADDR_SM      = 2'h1;
  // physical layer control fields
  localparam int unsigned PHY_ACTIVE   = 4;
  localparam int unsigned PHY_SLOPE    = 3;
  localparam int unsigned PHY_DRIVE    = 2;
  localparam int unsigned PHY_TXDIS    = 0;
  // special mode fields
  localparam int unsigned SM_SDM       = 9;
  localparam int unsigned SM_PRE_LO    = 5;
  localparam int unsigned SM_THR_LO    = 3;
  // register values after reset
  localparam logic [3:0]  PHY_RESET    = 4'h0;
  localparam logic [4:0]  SM_RESET     = 5'h00;
  // prescale factor times two per code: 1, 1.5, 2.5, 3.5
  localparam logic [2:0]  PRE_X2_0     = 3'h2;
  localparam logic [2:0]  PRE_X2_1     = 3'h3;
  localparam logic [2:0]  PRE_X2_2     = 3'h5;
  localparam logic [2:0]  PRE_X2_3     = 3'h7;
  // reset threshold in percent of nominal per code: 90, 80, 70, 90
  localparam logic [6:0]  THR_PCT_0    = 7'h5a;
  localparam logic [6:0]  THR_PCT_1    = 7'h50;
  localparam logic [6:0]  THR_PCT_2    = 7'h46;
  localparam logic [6:0]  THR_PCT_3    = 7'h5a;
  // host register map, byte addresses
  localparam logic [3:0]  REG_CMD      = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [3:0]  REG_RESP     = 4'h8;
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_DONE      = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // link clock made by the host from its own clock
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned SCLK_HALF      =
    LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ### verilog/lin_cfg_if.sv
/*
  four-wire frame link between the configuration host and the device.
  assumes the host drives clock, select and data out; device drives data back.
*/
`timescale 1ns/1ps
interface lin_cfg_if;
  logic sclk;
  logic csn_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input csn_n, input mosi, output miso);
  modport host   (output sclk, output csn_n, output mosi, input miso);
endinterface

// ### verilog/lin_phy_sm_end.sv
/*
  device end: receives 16-bit command frames, holds the physical layer
  control and special mode registers, returns feedback in the same frame.
  assumes link pins are asynchronous to clk; other inputs are on clk.
*/
`timescale 1ns/1ps
module lin_phy_sm_end (
  input  wire logic       clk,
  input  wire logic       reset,
  lin_cfg_if.device       link,
  input  wire logic       normal_or_flash,
  input  wire logic       iface_fail,
  input  wire logic       lin_traffic_ok,
  input  wire logic [11:0] gp1_feedback,
  input  wire logic [11:0] int_en_feedback,
  output logic            lin_active_enable,
  output logic            lin_slope_select,
  output logic            lin_drive_strength,
  output logic            lin_tx_disable,
  output logic            lin_tx_off,
  output logic            iface_fail_flag,
  output logic            sw_dev_mode_init,
  output logic [1:0]      wdog_prescale,
  output logic [2:0]      wdog_scale_x2,
  output logic [1:0]      supply_reset_threshold,
  output logic [6:0]      supply_thresh_pct
);

  // link pin synchronisers; stage 1 feeds stage 2 only
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic csn_s1_r;
  logic csn_s2_r;
  logic csn_s3_r;
  logic mosi_s1_r;
  logic mosi_s2_r;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      csn_s1_r  <= 1'b1;
      csn_s2_r  <= 1'b1;
      csn_s3_r  <= 1'b1;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end
    else
    begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      csn_s1_r  <= link.csn_n;
      csn_s2_r  <= csn_s1_r;
      csn_s3_r  <= csn_s2_r;
      mosi_s1_r <= link.mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  wire sclk_rise  = sclk_s2_r & ~sclk_s3_r;
  wire sclk_fall  = ~sclk_s2_r & sclk_s3_r;
  wire frame_on   = ~csn_s2_r;
  wire frame_open = ~csn_s2_r & csn_s3_r;
  wire frame_shut = csn_s2_r & ~csn_s3_r;

  // frame receive state
  logic [15:0] rx_r;
  logic [4:0]  cnt_r;
  logic [2:0]  hdr_r;
  logic        miso_r;

  // stored registers
  logic       phy_active_r;
  logic       phy_slope_r;
  logic       phy_drive_r;
  logic       phy_txdis_r;
  logic       sm_sdm_r;
  logic [1:0] sm_pre_r;
  logic [1:0] sm_thr_r;
  logic       fail_r;

  wire full_frame = (cnt_r == 5'(lin_cfg_pkg::FRAME_BITS));
  wire [1:0] rx_addr =
    rx_r[lin_cfg_pkg::ADDR_HI:lin_cfg_pkg::ADDR_LO];
  wire store_ok   = frame_shut & full_frame &
                    ~rx_r[lin_cfg_pkg::INHIBIT_BIT];
  wire store_phy  = store_ok & (rx_addr == lin_cfg_pkg::ADDR_PHY);
  wire store_sm   = store_ok & (rx_addr == lin_cfg_pkg::ADDR_SM);

  // feedback words, reserved positions read as zero
  wire [11:0] phy_fb = {7'h00, phy_active_r, phy_slope_r, phy_drive_r,
                        1'b0, phy_txdis_r};
  wire [11:0] sm_fb  = {2'h0, sm_sdm_r, 2'h0, sm_pre_r, sm_thr_r, 3'h0};

  wire hdr_phy = (hdr_r[2:1] == lin_cfg_pkg::ADDR_PHY);
  wire hdr_sm  = (hdr_r[2:1] == lin_cfg_pkg::ADDR_SM);
  wire [11:0] sel_fb =
    hdr_phy ? (hdr_r[0] ? gp1_feedback : phy_fb) :
    hdr_sm  ? (hdr_r[0] ? sm_fb : int_en_feedback) :
    12'h000;
  wire [15:0] resp   = {4'h0, sel_fb};
  wire [3:0]  out_ix = 4'(15 - cnt_r);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_r   <= 16'h0000;
      cnt_r  <= 5'h00;
      hdr_r  <= 3'h0;
      miso_r <= 1'b0;
    end
    else if (frame_open)
    begin
      cnt_r  <= 5'h00;
      hdr_r  <= 3'h0;
      miso_r <= 1'b0;
    end
    else if (frame_on)
    begin
      // count past sixteen so that an overlong frame stores nothing
      if (sclk_rise && cnt_r != 5'h1f)
      begin
        rx_r  <= {rx_r[14:0], mosi_s2_r};
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == 5'h02)
          hdr_r <= {rx_r[1:0], mosi_s2_r};
      end
      if (sclk_fall && cnt_r >= 5'h03 &&
          cnt_r < 5'(lin_cfg_pkg::FRAME_BITS))
        miso_r <= resp[out_ix];
    end
  end

  // transmitter disable edge from one to zero forces recovery
  wire txdis_clear = store_phy & phy_txdis_r &
                     ~rx_r[lin_cfg_pkg::PHY_TXDIS];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {phy_active_r, phy_slope_r, phy_drive_r, phy_txdis_r} <=
        lin_cfg_pkg::PHY_RESET;
    end
    else if (store_phy)
    begin
      phy_active_r <= rx_r[lin_cfg_pkg::PHY_ACTIVE];
      phy_slope_r  <= rx_r[lin_cfg_pkg::PHY_SLOPE];
      phy_drive_r  <= rx_r[lin_cfg_pkg::PHY_DRIVE];
      phy_txdis_r  <= rx_r[lin_cfg_pkg::PHY_TXDIS];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {sm_sdm_r, sm_pre_r, sm_thr_r} <= lin_cfg_pkg::SM_RESET;
    end
    else if (store_sm)
    begin
      sm_sdm_r <= rx_r[lin_cfg_pkg::SM_SDM];
      sm_pre_r <= rx_r[lin_cfg_pkg::SM_PRE_LO +: 2];
      sm_thr_r <= rx_r[lin_cfg_pkg::SM_THR_LO +: 2];
    end
  end

  // failure latch: a new failure wins over any recovery in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      fail_r <= 1'b0;
    else if (iface_fail)
      fail_r <= 1'b1;
    else if (lin_traffic_ok || txdis_clear)
      fail_r <= 1'b0;
  end

  wire [2:0] pre_x2 =
    (sm_pre_r == 2'h0) ? lin_cfg_pkg::PRE_X2_0 :
    (sm_pre_r == 2'h1) ? lin_cfg_pkg::PRE_X2_1 :
    (sm_pre_r == 2'h2) ? lin_cfg_pkg::PRE_X2_2 :
                         lin_cfg_pkg::PRE_X2_3;
  wire [6:0] thr_pct =
    (sm_thr_r == 2'h0) ? lin_cfg_pkg::THR_PCT_0 :
    (sm_thr_r == 2'h1) ? lin_cfg_pkg::THR_PCT_1 :
    (sm_thr_r == 2'h2) ? lin_cfg_pkg::THR_PCT_2 :
                         lin_cfg_pkg::THR_PCT_3;

  // all user outputs registered
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lin_active_enable      <= 1'b0;
      lin_slope_select       <= 1'b0;
      lin_drive_strength     <= 1'b0;
      lin_tx_disable         <= 1'b0;
      lin_tx_off             <= 1'b0;
      iface_fail_flag        <= 1'b0;
      sw_dev_mode_init       <= 1'b0;
      wdog_prescale          <= 2'h0;
      wdog_scale_x2          <= lin_cfg_pkg::PRE_X2_0;
      supply_reset_threshold <= 2'h0;
      supply_thresh_pct      <= lin_cfg_pkg::THR_PCT_0;
    end
    else
    begin
      lin_active_enable      <= phy_active_r & normal_or_flash;
      lin_slope_select       <= phy_slope_r;
      lin_drive_strength     <= phy_drive_r;
      lin_tx_disable         <= phy_txdis_r;
      lin_tx_off             <= phy_txdis_r | fail_r;
      iface_fail_flag        <= fail_r;
      sw_dev_mode_init       <= sm_sdm_r;
      wdog_prescale          <= sm_pre_r;
      wdog_scale_x2          <= pre_x2;
      supply_reset_threshold <= sm_thr_r;
      supply_thresh_pct      <= thr_pct;
    end
  end

  assign link.miso = miso_r;

endmodule // lin_phy_sm_end

// ### verif/lin_cfg_asserts.sv
/*
  concurrent checks on the four-wire frame link between host and device.
  assumes it watches the interface that joins the two design ends.
*/
`timescale 1ns/1ps
module lin_cfg_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csn_n,
  input wire logic mosi,
  input wire logic miso
);
  logic       sclk_d_r;
  logic [4:0] rise_cnt_r;
  logic [4:0] rise_cnt_nxt;
  wire        sclk_rise = sclk & ~sclk_d_r;

  // link clock rises counted within one frame
  assign rise_cnt_nxt = csn_n ? 5'h00 : rise_cnt_r + {4'h0, sclk_rise};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sclk_d_r   <= 1'b0;
      rise_cnt_r <= 5'h00;
    end
    else
    begin
      sclk_d_r   <= sclk;
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_idle_clk_low: assert property (csn_n |-> !sclk)
    else $error("link clock high outside a frame");
  chk_clk_high_width: assert property (
    $rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase not eight cycles");
  chk_clk_low_width: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase shorter than eight cycles");
  chk_first_rise: assert property (
    $fell(csn_n) |-> !sclk [*8] ##1 sclk)
    else $error("first clock rise not eight cycles after select");
  chk_mosi_held: assert property (sclk |-> $stable(mosi))
    else $error("host data changed while link clock high");
  chk_miso_held: assert property (sclk |-> $stable(miso))
    else $error("answer data changed while link clock high");
  chk_rise_count: assert property (
    $rose(csn_n) |-> rise_cnt_r == 5'h10)
    else $error("frame did not carry sixteen clock rises");
  chk_last_fall_gap: assert property (
    $rose(csn_n) |-> $past(sclk, 9) && !$past(sclk, 8))
    else $error("select released at wrong distance from last fall");

  cover property ($rose(csn_n));
  cover property (sclk && miso);
  cover property ($fell(csn_n) ##1 mosi);
endmodule // lin_cfg_asserts

// ### verif/tb.sv
/*
  self-checking bench: host and device ends joined by the link interface,
  host driven over AXI4-Lite, device side inputs driven by the bench.
  assumes the shared package and interface are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        reset;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic        nof, ifail, tok, fl;
  logic [11:0] gp1, ien;
  wire  [20:0] outs;
  logic [3:0]  phy;
  logic [4:0]  sm;
  logic [33:0] bq[$], rq[$];
  logic [2:0]  x2_tab[4];
  logic [6:0]  pct_tab[4];
  int          mismatches, num_checks;

  lin_cfg_if lnk ();
  lin_cfg_host i_lin_cfg_host (.clk(clk), .reset(reset), .link(lnk.host),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lin_phy_sm_end i_lin_phy_sm_end (.clk(clk), .reset(reset),
    .link(lnk.device), .normal_or_flash(nof), .iface_fail(ifail),
    .lin_traffic_ok(tok), .gp1_feedback(gp1), .int_en_feedback(ien),
    .lin_active_enable(outs[20]), .lin_slope_select(outs[19]),
    .lin_drive_strength(outs[18]), .lin_tx_disable(outs[17]),
    .lin_tx_off(outs[16]), .iface_fail_flag(outs[15]),
    .sw_dev_mode_init(outs[14]), .wdog_prescale(outs[13:12]),
    .wdog_scale_x2(outs[11:9]), .supply_reset_threshold(outs[8:7]),
    .supply_thresh_pct(outs[6:0]));
  lin_cfg_asserts i_lin_cfg_asserts (.clk(clk), .reset(reset),
    .sclk(lnk.sclk), .csn_n(lnk.csn_n), .mosi(lnk.mosi), .miso(lnk.miso));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // results are compared as they appear, against the oldest note
  always @(posedge clk)
  begin
    if (bvalid && bready)
      check("bresp", {32'h0, bresp}, bq.pop_front());
    if (rvalid && rready)
      check("rdata", {rresp, rdata}, rq.pop_front());
  end

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    bq.push_back({32'h0, er});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end
    while (awvalid || wvalid || bready);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    rq.push_back({er, ed});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end
    while (arvalid || rready);
  endtask

  // one command frame; the answer word is checked against fb
  task automatic frame(input logic [15:0] f, input logic [11:0] fb);
    int n;
    axi_wr(lin_cfg_pkg::REG_CMD, {16'h0, f}, 4'hf, lin_cfg_pkg::RESP_OKAY);
    axi_rd(lin_cfg_pkg::REG_STATUS, 32'h1, lin_cfg_pkg::RESP_OKAY);
    n = 0;
    while (lnk.csn_n && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    while (!lnk.csn_n && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check("frame time", {33'h0, n < 400}, 34'h1);
    repeat (8) @(posedge clk);
    axi_rd(lin_cfg_pkg::REG_STATUS, 32'h2, lin_cfg_pkg::RESP_OKAY);
    axi_wr(lin_cfg_pkg::REG_STATUS, 32'h2, 4'hf, lin_cfg_pkg::RESP_OKAY);
    axi_rd(lin_cfg_pkg::REG_RESP, {20'h0, fb}, lin_cfg_pkg::RESP_OKAY);
  endtask

  task automatic pulse(input bit fail);
    @(posedge clk);
    if (fail) ifail <= 1'b1;
    else tok <= 1'b1;
    @(posedge clk);
    ifail <= 1'b0;
    tok <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  function automatic logic [11:0] phy_fb();
    return {7'h0, phy[3:1], 1'b0, phy[0]};
  endfunction

  function automatic logic [11:0] sm_fb();
    return {2'h0, sm[4], 2'h0, sm[3:0], 3'h0};
  endfunction

  function automatic logic [33:0] exp_outs();
    return {13'h0, phy[3] & nof, phy[2:1], phy[0], phy[0] | fl, fl, sm[4],
            sm[3:2], x2_tab[sm[3:2]], sm[1:0], pct_tab[sm[1:0]]};
  endfunction

  task automatic chk_outs();
    check("outputs", {13'h0, outs}, exp_outs());
  endtask

  initial
  begin
    {awaddr, araddr, wstrb, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, nof, ifail, tok, gp1, ien} = '0;
    {phy, sm, fl, mismatches, num_checks} = '0;
    reset = 1'b1;
    x2_tab = '{3'h2, 3'h3, 3'h5, 3'h7};
    pct_tab = '{7'h5a, 7'h50, 7'h46, 7'h5a};
    void'($urandom(32'h30b3));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    chk_outs();
    axi_rd(4'hc, 32'h0, lin_cfg_pkg::RESP_SLVERR);
    axi_wr(4'hc, 32'h0, 4'hf, lin_cfg_pkg::RESP_SLVERR);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      ien <= r[11:0];
      frame({4'h6, 2'h0, r[12], 2'h0, i[1:0], ~i[1:0], 3'h0}, sm_fb());
      sm = {r[12], i[1:0], ~i[1:0]};
      chk_outs();
    end
    frame({4'h5, 2'h0, 1'b1, 2'h0, 4'hf, 3'h0}, ien);
    chk_outs();
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      nof <= r[4];
      gp1 <= r[27:16];
      frame({4'hc, 7'h0, r[3:1], 1'b0, r[0]}, phy_fb());
      phy = r[3:0];
      chk_outs();
      frame({4'hf, 7'h0, ~r[3:1], 1'b0, ~r[0]}, gp1);
      chk_outs();
    end
    frame(16'hffff, gp1);
    axi_rd(lin_cfg_pkg::REG_CMD, 32'hf01d, lin_cfg_pkg::RESP_OKAY);
    frame(16'h7fff, sm_fb());
    axi_rd(lin_cfg_pkg::REG_CMD, 32'h7278, lin_cfg_pkg::RESP_OKAY);
    frame(16'h8000, 12'h0);
    chk_outs();
    frame(16'hc000, phy_fb());
    phy = 4'h0;
    pulse(1'b1);
    fl = 1'b1;
    chk_outs();
    pulse(1'b0);
    fl = 1'b0;
    chk_outs();
    pulse(1'b1);
    fl = 1'b1;
    frame(16'hc001, phy_fb());
    phy = 4'h1;
    chk_outs();
    frame(16'hc000, phy_fb());
    phy = 4'h0;
    fl = 1'b0;
    chk_outs();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb
